//--- src/lrt_pkg.sv
// Shared constants for the low rate clock timer: register map, fields and bus codes.
package lrt_pkg;
  // Data widths.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned TAP_N  = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CONTROL = 16'h5000;
  localparam logic [15:0] IDX_COUNT   = 16'h5001;
  localparam logic [15:0] IDX_ENABLE  = 16'h5002;
  localparam logic [15:0] IDX_PENDING = 16'h5003;
  localparam int unsigned BYTE_SHIFT  = 2;

  // Control register fields.
  localparam int unsigned RUN_BIT   = 0;
  localparam int unsigned CLEAR_BIT = 4;

  // Flag and enable bit per tap: 1 Hz, 2 Hz, 8 Hz, 32 Hz.
  localparam int unsigned FLAG_1HZ  = 0;
  localparam int unsigned FLAG_2HZ  = 1;
  localparam int unsigned FLAG_8HZ  = 2;
  localparam int unsigned FLAG_32HZ = 3;

  // Counter bit that carries each tap, indexed like the flags.
  localparam int unsigned TAP_POS [TAP_N] = '{7, 6, 4, 2};

  // Reset values.
  localparam logic [CNT_W-1:0] CNT_RESET  = 8'h00;
  localparam logic [TAP_N-1:0] FLAG_RESET = 4'h0;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register select produced by the address decoder.
  typedef enum logic [2:0] {
    SEL_CONTROL = 3'b000,
    SEL_COUNT   = 3'b001,
    SEL_ENABLE  = 3'b010,
    SEL_PENDING = 3'b011,
    SEL_NONE    = 3'b100
  } lrt_sel_t;
endpackage : lrt_pkg

//--- src/lrt_count_core.sv
// Tick synchroniser, run gating and the 8-bit tap counter of the low rate timer.
`timescale 1ns/1ps
`default_nettype none
module lrt_count_core
  import lrt_pkg::*;
#(
  parameter int unsigned CW = CNT_W
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            tick_in,
  input  wire logic            sleep_in,
  input  wire logic            run_req,
  input  wire logic            clear,
  output var  logic [CW-1:0]   count,
  output var  logic            running,
  output var  logic [TAP_N-1:0] tap_fall
);
  logic tick_s1_ff;
  logic tick_s2_ff;
  logic tick_s3_ff;
  logic sleep_s1_ff;
  logic sleep_s2_ff;
  logic tick_fall;
  logic step;
  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic          run_act_ff;
  logic [TAP_N-1:0] tap_ff;
  logic [TAP_N-1:0] nxt_tap;

  // Both pins come from other clock domains, so each passes two flops first.
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_s1_ff  <= 1'b0;
      tick_s2_ff  <= 1'b0;
      tick_s3_ff  <= 1'b0;
      sleep_s1_ff <= 1'b0;
      sleep_s2_ff <= 1'b0;
    end else begin
      tick_s1_ff  <= tick_in;
      tick_s2_ff  <= tick_s1_ff;
      tick_s3_ff  <= tick_s2_ff;
      sleep_s1_ff <= sleep_in;
      sleep_s2_ff <= sleep_s1_ff;
    end
  end

  // A tick falling edge counts only while sleep is off.
  assign tick_fall = tick_s3_ff & ~tick_s2_ff;
  assign step      = tick_fall & ~sleep_s2_ff;

  // The run state follows the request only at a tick falling edge; since the
  // old state still decides that edge, a stop lets one more count through.
  always_ff @(posedge clk) begin
    if (rst) begin
      run_act_ff <= 1'b0;
    end else if (step) begin
      run_act_ff <= run_req;
    end
  end

  // Clear beats the increment; stopped counts hold their value.
  always_comb begin
    nxt_count = count_ff;
    if (clear) begin
      nxt_count = CNT_RESET;
    end else if (step && run_act_ff) begin
      nxt_count = count_ff + CW'(1);
    end
  end

  // A tap falls when its bit goes from one to zero on an increment.
  always_comb begin
    nxt_tap = '0;
    for (int i = 0; i < TAP_N; i++) begin
      nxt_tap[i] = !clear && step && run_act_ff &&
                   count_ff[TAP_POS[i]] && !nxt_count[TAP_POS[i]];
    end
  end

  // Counter and tap pulses.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= CNT_RESET;
      tap_ff   <= '0;
    end else begin
      count_ff <= nxt_count;
      tap_ff   <= nxt_tap;
    end
  end

  assign count    = count_ff;
  assign running  = run_act_ff;
  assign tap_fall = tap_ff;
endmodule : lrt_count_core
`default_nettype wire

//--- src/lrt_timer.sv
// Low rate clock timer top: AXI4-Lite register slave, flags and interrupt line.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Run bit D0 starts counting when written 1, halts when written 0; resets 0.
// - Stopping and starting keeps the counter value; counting resumes from it.
// - Writing run and reset together clears the counter, then counts from zero.
// - Run and stop take effect at the next falling edge of the 256 Hz tick.
// - After a stop request the counter advances one more count before halting.
// - The run bit reads 1 after a stop request until counting really halts.
// - Falling edges of the 32, 8, 2 and 1 Hz taps set own flags.
// - One shared interrupt line is high while any enabled flag is pending.
// - Enable bits D3..D0 for 32, 8, 2, 1 Hz; all reset to disabled.
// - Writing 1 to a flag clears it, writing 0 does nothing; flags reset 0.
// - Flags sit in D3..D0 of the flag register; upper bits read zero.
// - Writing 1 to write-only bit D4 clears the counter; it reads 0.
// - A clear while running keeps counting from zero; stopped holds zero.
// - The 8-bit count is readable; writes to the count register do nothing.
// - The counter is 8-bit binary, stepped by the 256 Hz tick.
// - System reset also clears the counter, apart from the software bit.
// - No tick reaches the counter during sleep, so it does not advance.
module lrt_timer
  import lrt_pkg::*;
#(
  parameter int unsigned ADDR_W = 20
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  input  wire logic                 TICK_256HZ,
  input  wire logic                 SLEEP_ACTIVE,
  input  wire logic [ADDR_W-1:0]    AWADDR,
  input  wire logic [2:0]           AWPROT,
  input  wire logic                 AWVALID,
  output var  logic                 AWREADY,
  input  wire logic [DATA_W-1:0]    WDATA,
  input  wire logic [DATA_W/8-1:0]  WSTRB,
  input  wire logic                 WVALID,
  output var  logic                 WREADY,
  output var  logic [1:0]           BRESP,
  output var  logic                 BVALID,
  input  wire logic                 BREADY,
  input  wire logic [ADDR_W-1:0]    ARADDR,
  input  wire logic [2:0]           ARPROT,
  input  wire logic                 ARVALID,
  output var  logic                 ARREADY,
  output var  logic [DATA_W-1:0]    RDATA,
  output var  logic [1:0]           RRESP,
  output var  logic                 RVALID,
  input  wire logic                 RREADY,
  output var  logic                 IRQ
);
  import lrt_pkg::*;

  // Decodes a byte address into a register select; misaligned is unmapped.
  function automatic lrt_sel_t decode(input logic [ADDR_W-1:0] addr);
    lrt_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_W'({IDX_CONTROL, 2'b00})) begin
      sel = SEL_CONTROL;
    end else if (addr == ADDR_W'({IDX_COUNT, 2'b00})) begin
      sel = SEL_COUNT;
    end else if (addr == ADDR_W'({IDX_ENABLE, 2'b00})) begin
      sel = SEL_ENABLE;
    end else if (addr == ADDR_W'({IDX_PENDING, 2'b00})) begin
      sel = SEL_PENDING;
    end
    return sel;
  endfunction : decode

  // Write channel state.
  logic                awready_ff;
  logic                wready_ff;
  logic                aw_held_ff;
  logic                w_held_ff;
  logic [ADDR_W-1:0]   awaddr_ff;
  logic [DATA_W-1:0]   wdata_ff;
  logic [DATA_W/8-1:0] wstrb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                nxt_aw_held;
  logic                nxt_w_held;
  logic                nxt_bvalid;
  logic                aw_hs;
  logic                w_hs;
  logic                do_write;
  lrt_sel_t            wr_sel;
  logic                wr_lane;

  // Read channel state.
  logic                arready_ff;
  logic                rvalid_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic [1:0]          rresp_ff;
  logic                nxt_rvalid;
  logic                ar_hs;
  lrt_sel_t            rd_sel;
  logic [DATA_W-1:0]   rd_word;

  // Timer registers and core view.
  logic                run_req_ff;
  logic [TAP_N-1:0]    enable_ff;
  logic [TAP_N-1:0]    pending_ff;
  logic [TAP_N-1:0]    nxt_pending;
  logic                irq_ff;
  logic                clear_pulse;
  logic [CNT_W-1:0]    count_val;
  logic                running;
  logic [TAP_N-1:0]    tap_fall;
  logic                run_read;

  // Handshakes on the three request channels.
  assign aw_hs = AWVALID & awready_ff;
  assign w_hs  = WVALID & wready_ff;
  assign ar_hs = ARVALID & arready_ff;

  // Address and data may arrive in either order; the write fires once both
  // are held and no response is still waiting.
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_sel   = decode(awaddr_ff);
  assign wr_lane  = wstrb_ff[0];

  // Next values of the write channel holders.
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_bvalid  = bvalid_ff;
    if (aw_hs) begin
      nxt_aw_held = 1'b1;
    end else if (do_write) begin
      nxt_aw_held = 1'b0;
    end
    if (w_hs) begin
      nxt_w_held = 1'b1;
    end else if (do_write) begin
      nxt_w_held = 1'b0;
    end
    if (do_write) begin
      nxt_bvalid = 1'b1;
    end else if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Write channel flops. Readies stay low until the response is taken, which
  // keeps only one write in flight and spares a buffer.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      if (do_write) begin
        bresp_ff <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Captured address and data.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= AWADDR;
      end
      if (w_hs) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
      end
    end
  end

  // The clear bit is a pulse, never stored, so it always reads back zero.
  assign clear_pulse = do_write && wr_lane && (wr_sel == SEL_CONTROL) &&
                       wdata_ff[CLEAR_BIT];

  // Run request bit.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      run_req_ff <= 1'b0;
    end else if (do_write && wr_lane && wr_sel == SEL_CONTROL) begin
      run_req_ff <= wdata_ff[RUN_BIT];
    end
  end

  // Interrupt enables.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      enable_ff <= FLAG_RESET;
    end else if (do_write && wr_lane && wr_sel == SEL_ENABLE) begin
      enable_ff <= wdata_ff[TAP_N-1:0];
    end
  end

  // Pending flags: a tap edge in the clearing cycle wins over the clear.
  always_comb begin
    nxt_pending = pending_ff;
    if (do_write && wr_lane && wr_sel == SEL_PENDING) begin
      nxt_pending = pending_ff & ~wdata_ff[TAP_N-1:0];
    end
    nxt_pending = nxt_pending | tap_fall;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pending_ff <= FLAG_RESET;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // One shared request line, registered so it is glitch free.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(pending_ff & enable_ff);
    end
  end

  // A stop request reads as running until the core has really halted.
  assign run_read = run_req_ff | running;

  // Read data mux; reserved bits and the clear bit read zero.
  assign rd_sel = decode(ARADDR);
  always_comb begin
    rd_word = '0;
    unique case (rd_sel)
      SEL_CONTROL: begin
        rd_word[RUN_BIT] = run_read;
      end
      SEL_COUNT: begin
        rd_word[CNT_W-1:0] = count_val;
      end
      SEL_ENABLE: begin
        rd_word[TAP_N-1:0] = enable_ff;
      end
      SEL_PENDING: begin
        rd_word[TAP_N-1:0] = pending_ff;
      end
      SEL_NONE: begin
        rd_word = '0;
      end
    endcase
  end

  // Read response valid, held until the master takes it.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    if (ar_hs) begin
      nxt_rvalid = 1'b1;
    end else if (rvalid_ff && RREADY) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Read channel flops; the data is sampled at the address handshake, so a
  // running count is captured whole from its register and one read is enough.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // Counter core; writes to the count register have no path into it.
  lrt_count_core #(
    .CW       (CNT_W)
  ) u_core (
    .clk      (SYS_CLK),
    .rst      (RST),
    .tick_in  (TICK_256HZ),
    .sleep_in (SLEEP_ACTIVE),
    .run_req  (run_req_ff),
    .clear    (clear_pulse),
    .count    (count_val),
    .running  (running),
    .tap_fall (tap_fall)
  );

  // Outputs straight from flops.
  assign AWREADY = awready_ff;
  assign WREADY  = wready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;
  assign IRQ     = irq_ff;
endmodule : lrt_timer
`default_nettype wire

//--- verification/lrt_tick_src.sv
// Model of the clock generator that supplies the 256 Hz count tick.
`timescale 1ns/1ps
`default_nettype none
module lrt_tick_src (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  output var  logic tick,
  output var  logic busy
);
  logic [2:0] ph_ff;
  // A pulse runs through eight phases so that the low part outlasts the synchroniser.
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_ff <= 3'h0;
    end else if (go || ph_ff != 3'h0) begin
      ph_ff <= ph_ff + 3'h1;
    end
  end
  // High for four cycles; only the fall advances the counter.
  always_comb begin
    tick = (ph_ff >= 3'h1) && (ph_ff <= 3'h4);
    busy = (ph_ff != 3'h0);
  end
endmodule : lrt_tick_src
`default_nettype wire

//--- verification/lrt_timer_chk.sv
// Port-level checker for the low rate timer register slave and interrupt line.
`timescale 1ns/1ps
`default_nettype none
module lrt_timer_chk #(
  parameter int unsigned ADDR_W = 20
) (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Answers hold until taken, and a busy slave refuses new requests.
  a_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("Write response dropped early.");
  a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read data dropped early.");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("Read taken while answer pending.");
  a_aw_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("Write taken while response pending.");
  a_b_latency: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("Write response late.");
  a_r_latency: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("Read answer late.");
  // The shared line only drops after a register write cleared a flag or an enable.
  a_irq_fall_cause: assert property ($fell(IRQ) |-> $past(BVALID))
    else $error("Interrupt dropped without a write.");
  a_irq_steady: assert property (!BVALID && $past(!BVALID) && IRQ |=> IRQ)
    else $error("Interrupt lost while no write was made.");
endmodule : lrt_timer_chk
bind lrt_timer lrt_timer_chk #(.ADDR_W(ADDR_W)) i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
  .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
  .RREADY(RREADY), .RDATA(RDATA), .IRQ(IRQ));
`default_nettype wire

//--- verification/tb_low_rate_clock_timer.sv
// Self-checking bench for the low rate timer over its AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module tb_low_rate_clock_timer;
  import lrt_pkg::*;
  localparam logic [19:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [19:0] A_CNT = {2'b00, IDX_COUNT, 2'b00};
  localparam logic [19:0] A_ENA = {2'b00, IDX_ENABLE, 2'b00};
  localparam logic [19:0] A_PND = {2'b00, IDX_PENDING, 2'b00};
  localparam logic [19:0] RA [5] = '{A_CTL, A_CNT, A_ENA, A_PND, 20'h14010};
  localparam logic [1:0]  RR [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        SLEEP_ACTIVE = 1'b0;
  logic        go = 1'b0;
  logic [19:0] AWADDR = '0;
  logic [19:0] ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        TICK_256HZ, busy, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0]  BRESP, RRESP, rr, br;
  logic [31:0] RDATA, rv;
  int          failures = 0;
  int          cmp_count = 0;
  // The 125 MHz system clock.
  always #4 SYS_CLK = ~SYS_CLK;
  lrt_tick_src i_tick (.clk(SYS_CLK), .rst(RST), .go(go), .tick(TICK_256HZ), .busy(busy));
  lrt_timer i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .TICK_256HZ(TICK_256HZ),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .IRQ(IRQ));
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk
  // A wait that runs out is counted and ends the run, since later steps lose meaning.
  task automatic hang(input int n);
    if (n > 60) begin
      failures++;
      $display("[FAIL] %0t wait ran out after %0h cycles", $time, n);
      complete_run();
    end
  endtask : hang
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
      hang(n);
    end while (BVALID !== 1'b1);
    br = BRESP;
    BREADY <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [19:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
      hang(n);
    end while (RVALID !== 1'b1);
    rv = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
    chk(rv, e);
  endtask : rchk
  task automatic irq_is(input logic e);
    @(posedge SYS_CLK);
    chk({31'h0, IRQ}, {31'h0, e});
  endtask : irq_is
  // Each tick is a full pulse plus time for its fall to pass the synchroniser.
  // The model's busy flag only settles after the edge, so it is read one edge later.
  task automatic tick(input int cnt);
    int n;
    repeat (cnt) begin
      @(posedge SYS_CLK) go <= 1'b1;
      @(posedge SYS_CLK) go <= 1'b0;
      n = 0;
      do begin
        @(posedge SYS_CLK);
        n++;
        hang(n);
      end while (busy === 1'b1);
      repeat (2) @(posedge SYS_CLK);
    end
  endtask : tick
  // Rows of address, reset data and response, with one unmapped place.
  task automatic regs();
    for (int i = 0; i < 5; i++) begin
      rchk(RA[i], 32'h0);
      chk({30'h0, rr}, {30'h0, RR[i]});
    end
  endtask : regs
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    regs();
    wr(A_PND, 32'hF);
    wr(A_ENA, 32'hFF);
    rchk(A_ENA, 32'hF);
    wr(A_CNT, 32'h55);
    chk({30'h0, br}, {30'h0, RESP_OKAY});
    rchk(A_CNT, 32'h0);
    wr(RA[4], 32'hFF);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    wr(A_CTL, 32'h11);
    rchk(A_CTL, 32'h1);
    tick(1);
    rchk(A_CNT, 32'h0);
    tick(2);
    rchk(A_CNT, 32'h2);
    wr(A_CTL, 32'h0);
    rchk(A_CTL, 32'h1);
    tick(1);
    rchk(A_CNT, 32'h3);
    rchk(A_CTL, 32'h0);
    tick(2);
    rchk(A_CNT, 32'h3);
    wr(A_CTL, 32'h1);
    tick(2);
    rchk(A_CNT, 32'h4);
    wr(A_CTL, 32'h11);
    rchk(A_CNT, 32'h0);
    tick(1);
    rchk(A_CNT, 32'h1);
    tick(7);
    rchk(A_CNT, 32'h8);
    rchk(A_PND, 32'h8);
    irq_is(1'b1);
    wr(A_PND, 32'h0);
    rchk(A_PND, 32'h8);
    wr(A_PND, 32'h8);
    rchk(A_PND, 32'h0);
    irq_is(1'b0);
    tick(248);
    rchk(A_CNT, 32'h0);
    rchk(A_PND, 32'hF);
    wr(A_ENA, 32'h0);
    irq_is(1'b0);
    wr(A_ENA, 32'h1);
    irq_is(1'b1);
    SLEEP_ACTIVE <= 1'b1;
    tick(3);
    rchk(A_CNT, 32'h0);
    SLEEP_ACTIVE <= 1'b0;
    tick(1);
    rchk(A_CNT, 32'h1);
    wr(A_CTL, 32'h0);
    tick(1);
    wr(A_CTL, 32'h10);
    tick(2);
    rchk(A_CNT, 32'h0);
    wr(A_CTL, 32'h1);
    tick(3);
    rchk(A_CNT, 32'h2);
    rchk(A_CNT, 32'h2);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    regs();
    irq_is(1'b0);
    complete_run();
  end
endmodule : tb_low_rate_clock_timer
`default_nettype wire
